// ---- common/spio_map.vh ----
// register indices, implemented-bit masks and bus constants for the shared io ports
`ifndef SPIO_MAP_VH
`define SPIO_MAP_VH

// register indices; byte address is four times the index
`define SPIO_DIR_A_IDX 10'h2c0
`define SPIO_LVL_A_IDX 10'h2c2
`define SPIO_LAT_A_IDX 10'h2c4
`define SPIO_DIR_B_IDX 10'h2c6
`define SPIO_LVL_B_IDX 10'h2c8
`define SPIO_LAT_B_IDX 10'h2cb
`define SPIO_DIR_C_IDX 10'h2cc
`define SPIO_LVL_C_IDX 10'h2ce
`define SPIO_LAT_C_IDX 10'h2d0
`define SPIO_DIR_D_IDX 10'h2d2
`define SPIO_LVL_D_IDX 10'h2d4
`define SPIO_LAT_D_IDX 10'h2d6
`define SPIO_DIR_E_IDX 10'h2d8
`define SPIO_LVL_E_IDX 10'h2da
`define SPIO_LAT_E_IDX 10'h2dc
`define SPIO_LVL_F_IDX 10'h2e0
`define SPIO_LAT_F_IDX 10'h2e2
`define SPIO_DIR_G_IDX 10'h2e4
`define SPIO_LVL_G_IDX 10'h2e6
`define SPIO_LAT_G_IDX 10'h2e8
`define SPIO_DIR_F_IDX 10'h2ee

// implemented bits; the direction reset pattern equals this mask
`define SPIO_IMPL_A 16'hc600
`define SPIO_IMPL_B 16'hffff
`define SPIO_IMPL_C 16'he00a
`define SPIO_IMPL_D 16'hffff
`define SPIO_IMPL_E 16'h03ff
`define SPIO_IMPL_F 16'h01ff
`define SPIO_IMPL_G 16'h03cf

// latch and pin-level reset value
`define SPIO_DATA_RST 16'h0000

// index field position inside the byte address
`define SPIO_IDX_LSB 2
`define SPIO_IDX_W 10
`define SPIO_ADDR_W 12

// width of one port
`define SPIO_PORT_W 16
// number of ports
`define SPIO_NPORT 7

// instruction cycle divider: clocks per instruction cycle
`define SPIO_CYC_DIV 1

`endif

// ---- hw/spio_ports.v ----
// shared parallel io ports a..g with apb register access and pad muxing
`timescale 1ns/100ps
`include "spio_map.vh"

// Overview of operation
// - direction bit one is input, zero output
// - reset makes every implemented pin input
// - latch register reads and writes latch only
// - pin-level reads pins, writes go to latch
// - active peripheral disables port driver, readable
// - idle enabled peripheral lets port drive pin
// - per-pad mux pair, peripheral wins
// - unimplemented bits disabled and read zero
// - input-only shared pin acts as dedicated
// - port a direction also steers shared functions
// - analog-configured pins read zero as level
// - reset clears data, loads direction patterns
module spio_ports #(
    parameter PORT_W = `SPIO_PORT_W,
    parameter NPORT = `SPIO_NPORT,
    parameter CYC_DIV = `SPIO_CYC_DIV
) (
    input wire sys_clk_i, // system clock, 10 mhz
    input wire arst_n_i, // async reset, active low
    input wire psel_i, // apb select
    input wire penable_i, // apb access phase
    input wire pwrite_i, // apb write
    input wire [`SPIO_ADDR_W-1:0] paddr_i, // apb byte address
    input wire [31:0] pwdata_i, // apb write data
    input wire [3:0] pstrb_i, // apb byte strobes
    output wire [31:0] prdata_o, // apb read data
    output wire pready_o, // apb ready
    output wire pslverr_o, // apb error on unmapped address
    input wire [PORT_W*NPORT-1:0] pad_in_i, // pad input buffers, port a low
    output wire [PORT_W*NPORT-1:0] pad_out_o, // pad output data
    output wire [PORT_W*NPORT-1:0] pad_oe_n_o, // pad output enable, low drives
    input wire [PORT_W*NPORT-1:0] periph_en_i, // peripheral owning the pad enabled
    input wire [PORT_W*NPORT-1:0] periph_drive_i, // peripheral actively driving
    input wire [PORT_W*NPORT-1:0] periph_out_i, // peripheral output data
    input wire [PORT_W*NPORT-1:0] periph_oe_n_i, // peripheral output enable, low drives
    input wire [PORT_W-1:0] analog_pin_config_i, // port b pins set analog when 0
    output wire [PORT_W-1:0] first_bank_dir_o, // port a direction for shared functions
    output wire [PORT_W*NPORT-1:0] pin_level_o // sampled pin levels
);

    localparam IW = `SPIO_IDX_W;
    localparam ALL = PORT_W * NPORT;

    localparam [IW*7-1:0] DIR_IDX = {
        `SPIO_DIR_G_IDX, `SPIO_DIR_F_IDX, `SPIO_DIR_E_IDX, `SPIO_DIR_D_IDX,
        `SPIO_DIR_C_IDX, `SPIO_DIR_B_IDX, `SPIO_DIR_A_IDX};
    localparam [IW*7-1:0] LVL_IDX = {
        `SPIO_LVL_G_IDX, `SPIO_LVL_F_IDX, `SPIO_LVL_E_IDX, `SPIO_LVL_D_IDX,
        `SPIO_LVL_C_IDX, `SPIO_LVL_B_IDX, `SPIO_LVL_A_IDX};
    localparam [IW*7-1:0] LAT_IDX = {
        `SPIO_LAT_G_IDX, `SPIO_LAT_F_IDX, `SPIO_LAT_E_IDX, `SPIO_LAT_D_IDX,
        `SPIO_LAT_C_IDX, `SPIO_LAT_B_IDX, `SPIO_LAT_A_IDX};
    localparam [16*7-1:0] IMPL = {
        `SPIO_IMPL_G, `SPIO_IMPL_F, `SPIO_IMPL_E, `SPIO_IMPL_D,
        `SPIO_IMPL_C, `SPIO_IMPL_B, `SPIO_IMPL_A};

    // analog configuration only exists on port b
    localparam PORT_B = 1;

    // instruction cycle divider
    reg [7:0] cyc_cnt_ff;
    reg [7:0] nxt_cyc_cnt;
    wire cyc_tick;

    assign cyc_tick = (cyc_cnt_ff == 8'h00);

    always @*
    begin
        if (cyc_tick)
            nxt_cyc_cnt = CYC_DIV[7:0] - 8'h01;
        else
            nxt_cyc_cnt = cyc_cnt_ff - 8'h01;
    end

    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cyc_cnt_ff <= 8'h00;
        else
            cyc_cnt_ff <= nxt_cyc_cnt;
    end

    // apb phase decode
    wire [IW-1:0] idx;
    wire setup_ph;
    wire wr_acc;
    wire [15:0] wmask;

    assign idx = paddr_i[`SPIO_IDX_LSB +: IW];
    assign setup_ph = psel_i & ~penable_i;
    // zero wait state: every access phase completes at once
    assign pready_o = 1'b1;
    assign wr_acc = psel_i & penable_i & pwrite_i & pready_o;
    assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

    wire [NPORT-1:0] dir_hit;
    wire [NPORT-1:0] lvl_hit;
    wire [NPORT-1:0] lat_hit;
    wire [ALL-1:0] dir_all;
    wire [ALL-1:0] lat_all;
    wire [ALL-1:0] lvl_all;

    genvar k;
    generate
        for (k = 0; k < NPORT; k = k + 1)
        begin : g_port
            localparam [15:0] MASK = IMPL[k*16 +: 16];
            wire [15:0] ana_zero;
            wire [15:0] pin_in;
            wire [15:0] p_en;
            wire [15:0] p_drv;
            wire [15:0] own;
            reg [15:0] dir_ff;
            reg [15:0] lat_ff;
            reg [15:0] lvl_ff;
            reg [15:0] nxt_dir;
            reg [15:0] nxt_lat;
            reg [15:0] nxt_lvl;

            assign dir_hit[k] = (idx == DIR_IDX[k*IW +: IW]);
            assign lvl_hit[k] = (idx == LVL_IDX[k*IW +: IW]);
            assign lat_hit[k] = (idx == LAT_IDX[k*IW +: IW]);

            if (k == PORT_B)
            begin : g_ana
                assign ana_zero = analog_pin_config_i;
            end
            else
            begin : g_dig
                assign ana_zero = 16'hffff;
            end

            assign pin_in = pad_in_i[k*16 +: 16];
            assign p_en = periph_en_i[k*16 +: 16];
            // an input-only peripheral never asserts drive, so the pin stays a port
            assign p_drv = p_en & periph_drive_i[k*16 +: 16];
            // an enabled but idle peripheral leaves the pad to the port
            assign own = p_drv & MASK;

            always @*
            begin
                nxt_dir = dir_ff;
                nxt_lat = lat_ff;
                nxt_lvl = lvl_ff;
                if (wr_acc && dir_hit[k])
                    nxt_dir = ((dir_ff & ~wmask) | (pwdata_i[15:0] & wmask)) & MASK;
                if (wr_acc && (lat_hit[k] || lvl_hit[k]))
                    nxt_lat = ((lat_ff & ~wmask) | (pwdata_i[15:0] & wmask)) & MASK;
                if (cyc_tick)
                    nxt_lvl = pin_in & ana_zero & MASK;
            end

            always @(posedge sys_clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    dir_ff <= MASK;
                    lat_ff <= `SPIO_DATA_RST;
                    lvl_ff <= `SPIO_DATA_RST;
                end
                else
                begin
                    dir_ff <= nxt_dir;
                    lat_ff <= nxt_lat;
                    lvl_ff <= nxt_lvl;
                end
            end

            // pad mux pair: data and enable, peripheral first
            assign pad_out_o[k*16 +: 16] =
                (own & periph_out_i[k*16 +: 16]) | (~own & lat_ff & MASK);
            assign pad_oe_n_o[k*16 +: 16] =
                (own & periph_oe_n_i[k*16 +: 16]) |
                (~own & (dir_ff | ~MASK));

            assign dir_all[k*16 +: 16] = dir_ff;
            assign lat_all[k*16 +: 16] = lat_ff;
            assign lvl_all[k*16 +: 16] = lvl_ff;
        end
    endgenerate

    // port a direction also controls interrupt and reference pins sharing it
    assign first_bank_dir_o = dir_all[15:0];
    assign pin_level_o = lvl_all;

    // read data is captured in the setup phase so it is a flop in the access phase
    reg [31:0] prdata_ff;
    reg [31:0] nxt_prdata;
    reg hit_any;
    integer j;

    always @*
    begin
        nxt_prdata = prdata_ff;
        hit_any = 1'b0;
        for (j = 0; j < NPORT; j = j + 1)
        begin
            if (dir_hit[j] || lvl_hit[j] || lat_hit[j])
                hit_any = 1'b1;
        end
        if (setup_ph && !pwrite_i)
        begin
            nxt_prdata = 32'h0000_0000;
            for (j = 0; j < NPORT; j = j + 1)
            begin
                if (dir_hit[j])
                    nxt_prdata[15:0] = dir_all[j*16 +: 16];
                if (lvl_hit[j])
                    nxt_prdata[15:0] = lvl_all[j*16 +: 16];
                if (lat_hit[j])
                    nxt_prdata[15:0] = lat_all[j*16 +: 16];
            end
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            prdata_ff <= 32'h0000_0000;
        else
            prdata_ff <= nxt_prdata;
    end

    assign prdata_o = prdata_ff;
    assign pslverr_o = psel_i & penable_i & ~hit_any;

endmodule // spio_ports

// ---- tb/spio_ports_monitor.sv ----
// checker for the shared io ports: apb answer, pad muxing and level sampling
`timescale 1ns/100ps
module spio_mon #(
    parameter PORT_W = 16,
    parameter NPORT = 7
) (
    input wire sys_clk_i, // clock
    input wire arst_n_i, // reset, active low
    input wire psel_i, // apb select
    input wire penable_i, // apb access
    input wire pwrite_i, // apb write
    input wire [11:0] paddr_i, // apb address
    input wire [31:0] pwdata_i, // apb data
    input wire [3:0] pstrb_i, // apb strobes
    input wire [31:0] prdata_o, // read data
    input wire pslverr_o, // apb error
    input wire [PORT_W*NPORT-1:0] pad_in_i, // pad levels
    input wire [PORT_W*NPORT-1:0] pad_out_o, // pad data
    input wire [PORT_W*NPORT-1:0] pad_oe_n_o, // pad enable
    input wire [PORT_W*NPORT-1:0] periph_en_i, // peripheral on
    input wire [PORT_W*NPORT-1:0] periph_drive_i, // peripheral driving
    input wire [PORT_W*NPORT-1:0] periph_out_i, // peripheral data
    input wire [PORT_W*NPORT-1:0] periph_oe_n_i, // peripheral enable
    input wire [PORT_W-1:0] analog_pin_config_i, // analog select
    input wire [PORT_W-1:0] first_bank_dir_o, // port a direction
    input wire [PORT_W*NPORT-1:0] pin_level_o // sampled levels
);
    localparam [111:0] IMPL = 112'h03cf_01ff_03ff_ffff_e00a_ffff_c600;
    // absent bits never hand the pad to a peripheral
    wire [111:0] own = periph_en_i & periph_drive_i & IMPL;
    wire acc = psel_i && penable_i;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    property p_err; pslverr_o |-> acc && (pwrite_i || prdata_o == 32'h0); endproperty
    a_err: assert property (p_err) else $error("error response misplaced");
    property p_rst; $rose(arst_n_i) |-> first_bank_dir_o == 16'hc600; endproperty
    a_rst: assert property (p_rst) else $error("direction not input after reset");
    property p_wdir; acc && pwrite_i && paddr_i == 12'hb00 && pstrb_i[1:0] == 2'h3
        |=> {16'h0, first_bank_dir_o} == ($past(pwdata_i) & 32'hc600); endproperty
    a_wdir: assert property (p_wdir) else $error("direction write lost");
    property p_hold; !(acc && pwrite_i) |=> $stable(first_bank_dir_o); endproperty
    a_hold: assert property (p_hold) else $error("direction moved");
    property p_own; (((pad_oe_n_o ^ periph_oe_n_i) | (pad_out_o ^ periph_out_i)) & own) == '0;
    endproperty
    a_own: assert property (p_own) else $error("peripheral lost the pad");
    property p_dir; ((pad_oe_n_o[15:0] ^ first_bank_dir_o) & ~own[15:0] & 16'hc600) == 16'h0;
    endproperty
    a_dir: assert property (p_dir) else $error("port enable differs from direction");
    property p_unimpl; ((((~pad_oe_n_o & ~own) | pin_level_o) & ~IMPL) == '0); endproperty
    a_unimpl: assert property (p_unimpl) else $error("absent bit active");
    property p_lvl; $past(arst_n_i) |-> pin_level_o == ($past(pad_in_i) & IMPL
        & {{80{1'b1}}, $past(analog_pin_config_i), 16'hffff}); endproperty
    a_lvl: assert property (p_lvl) else $error("level sample wrong");
    c_wdir: cover property (acc && pwrite_i && paddr_i == 12'hb00);
    c_err: cover property (pslverr_o);
    c_own: cover property (own != '0 && acc);
endmodule // spio_mon
bind spio_ports spio_mon #(.PORT_W(PORT_W), .NPORT(NPORT)) u_spio_mon (.*);

// ---- tb/spio_pad_model.sv ----
// outside world at the pads: block driver or an outside source sets each level
`timescale 1ns/100ps
module spio_pad_model (
    input wire [111:0] pad_out_i, // data from the block
    input wire [111:0] pad_oe_n_i, // enable, low drives
    input wire [111:0] ext_i, // outside source level
    output wire [111:0] pad_in_o // resolved pad level
);
    // a released pad shows the outside source, never stale block data
    assign pad_in_o = (pad_out_i & ~pad_oe_n_i) | (ext_i & pad_oe_n_i);
endmodule // spio_pad_model

// ---- tb/tb_shared_parallel_io_ports.sv ----
// self-checking bench for the shared io ports with random register and pad traffic
`timescale 1ns/100ps
module tb_shared_parallel_io_ports;
    localparam [111:0] IMPL = 112'h03cf_01ff_03ff_ffff_e00a_ffff_c600;
    reg sys_clk_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg psel_i = 1'b0;
    reg penable_i = 1'b0;
    reg pwrite_i = 1'b0;
    reg [11:0] paddr_i = 12'h0;
    reg [31:0] pwdata_i = 32'h0;
    reg [3:0] pstrb_i = 4'hf;
    reg [111:0] periph_en_i = 112'h0, periph_drive_i = 112'h0, periph_out_i = 112'h0;
    reg [111:0] periph_oe_n_i = 112'h0, ext = 112'h0, lat_e, dir_e, own, eoe, eout, ep;
    reg [15:0] analog_pin_config_i = 16'hffff, a;
    reg [31:0] r;
    reg e;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o;
    wire [111:0] pad_in_i, pad_out_o, pad_oe_n_o, pin_level_o;
    wire [15:0] first_bank_dir_o;
    integer fails = 0, checks_done = 0, seed = 32'h40d4, k, it;
    reg [9:0] dix [0:6] = '{10'h2c0, 10'h2c6, 10'h2cc, 10'h2d2, 10'h2d8, 10'h2ee, 10'h2e4};
    reg [9:0] lix [0:6] = '{10'h2c2, 10'h2c8, 10'h2ce, 10'h2d4, 10'h2da, 10'h2e0, 10'h2e6};
    reg [9:0] tix [0:6] = '{10'h2c4, 10'h2cb, 10'h2d0, 10'h2d6, 10'h2dc, 10'h2e2, 10'h2e8};
    spio_ports u_spio_ports (.*);
    spio_pad_model u_spio_pad_model (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .ext_i(ext), .pad_in_o(pad_in_i));
    always #50 sys_clk_i = ~sys_clk_i;
    function [111:0] lvl_exp(input [111:0] oe, input [111:0] dout);
        lvl_exp = ((~oe & dout) | (oe & ext)) & IMPL & {{80{1'b1}}, a, 16'hffff};
    endfunction
    task test_done;
        begin
            if (fails == 0 && checks_done > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [111:0] got, input [111:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                fails = fails + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // byte address is four times the index, since one printed offset is odd
    task apb(input w, input [9:0] ix, input [15:0] d, output [31:0] rd, output er);
        integer n;
        begin
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= {ix, 2'h0};
            pwdata_i <= {16'h0, d};
            @(posedge sys_clk_i);
            penable_i <= 1'b1;
            n = 0;
            do
            begin
                @(posedge sys_clk_i);
                n = n + 1;
            end
            while (pready_o !== 1'b1 && n < 16);
            if (n >= 16)
            begin
                fails = fails + 1;
                $display("[FAIL] %0t no ready", $time);
                test_done;
            end
            rd = prdata_o;
            er = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
            // one idle edge so the next call never reassigns psel in this time step
            @(posedge sys_clk_i);
        end
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        for (k = 0; k < 7; k = k + 1)
        begin
            apb(1'b0, dix[k], 16'h0, r, e);
            chk(r, IMPL[16*k +: 16]);
            apb(1'b0, lix[k], 16'h0, r, e);
            chk(r, 0);
            apb(1'b0, tix[k], 16'h0, r, e);
            chk(r, 0);
        end
        for (it = 0; it < 40; it = it + 1)
        begin
            a = $random(seed);
            analog_pin_config_i <= a;
            for (k = 0; k < 7; k = k + 1)
            begin
                lat_e[16*k +: 16] = $random(seed);
                dir_e[16*k +: 16] = $random(seed);
                ext[16*k +: 16] <= $random(seed);
                periph_en_i[16*k +: 16] <= $random(seed);
                periph_drive_i[16*k +: 16] <= $random(seed);
                periph_out_i[16*k +: 16] <= $random(seed);
                periph_oe_n_i[16*k +: 16] <= $random(seed);
            end
            dir_e[31:16] = dir_e[31:16] | ~a;
            for (k = 0; k < 7; k = k + 1)
            begin
                apb(1'b1, it[0] ? lix[k] : tix[k], lat_e[16*k +: 16], r, e);
                apb(1'b1, dix[k], dir_e[16*k +: 16], r, e);
            end
            lat_e = lat_e & IMPL;
            dir_e = dir_e & IMPL;
            @(posedge sys_clk_i);
            own = periph_en_i & periph_drive_i & IMPL;
            eoe = (own & periph_oe_n_i) | (~own & ~(~dir_e & IMPL));
            eout = (own & periph_out_i) | (~own & lat_e);
            ep = lvl_exp(eoe, eout);
            chk(pad_oe_n_o, eoe);
            chk(pad_out_o, eout);
            chk(first_bank_dir_o, dir_e[15:0]);
            for (k = 0; k < 7; k = k + 1)
            begin
                apb(1'b0, lix[k], 16'h0, r, e);
                chk(r, ep[16*k +: 16]);
                apb(1'b0, tix[k], 16'h0, r, e);
                chk(r, lat_e[16*k +: 16]);
                apb(1'b0, dix[k], 16'h0, r, e);
                chk(r, dir_e[16*k +: 16]);
            end
        end
        apb(1'b0, 10'h2de, 16'h0, r, e);
        chk({e, r}, 33'h1_0000_0000);
        test_done;
    end
endmodule // tb_shared_parallel_io_ports
